//--- include/pwmo_pkg.sv
package pwmo_pkg;

  // Wishbone geometry
  localparam int          WB_ADR_W   = 8;
  localparam int          WB_DAT_W   = 32;
  localparam int          WB_SEL_W   = 4;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  UNLOCK_OFS = 8'h04;
  localparam logic [7:0]  STATUS_OFS = 8'h08;

  // Control register fields
  localparam int          CTRL_W         = 16;
  localparam int          HIGH_OWNER_BIT = 15;
  localparam int          LOW_OWNER_BIT  = 14;
  localparam int          HIGH_POL_BIT   = 13;
  localparam int          LOW_POL_BIT    = 12;
  localparam int          MODE_LSB       = 10;
  localparam int          HIGH_OVR_BIT   = 9;
  localparam int          LOW_OVR_BIT    = 8;
  localparam int          OVR_LSB        = 6;
  localparam int          FLT_LSB        = 4;
  localparam int          CL_LSB         = 2;
  localparam int          SWAP_BIT       = 1;
  localparam int          ALIGN_BIT      = 0;
  localparam logic [15:0] CTRL_RESET     = 16'hc000;

  // Lock fuse and unlock keys
  localparam int          FUSE_W        = 8;
  localparam int          LOCK_FUSE_BIT = 0;
  localparam logic [15:0] UNLOCK_KEY1   = 16'h00aa;
  localparam logic [15:0] UNLOCK_KEY2   = 16'h0055;

  typedef enum logic [1:0] {
    MODE_COMPL     = 2'b00,
    MODE_REDUNDANT = 2'b01,
    MODE_PUSH_PULL = 2'b10,
    MODE_RESERVED  = 2'b11
  } pwmo_mode_t;

  typedef enum logic [1:0] {
    ULK_IDLE = 2'b00,
    ULK_HALF = 2'b01,
    ULK_OPEN = 2'b10
  } pwmo_ulk_t;

endpackage : pwmo_pkg

//--- src/pwmo_unlock.sv
`timescale 1ns/100ps
module pwmo_unlock (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        key_we_i,
  input  wire logic [15:0] key_i,
  input  wire logic        consume_i,
  output logic             open_o
);
  import pwmo_pkg::*;

  pwmo_ulk_t state;
  pwmo_ulk_t next_state;

  wire key1_hit = key_we_i && (key_i == UNLOCK_KEY1);
  wire key2_hit = key_we_i && (key_i == UNLOCK_KEY2);

  // Two keys back to back open one control write
  always_comb
  begin
    next_state = state;
    if (consume_i)
      next_state = ULK_IDLE;
    else if (key_we_i)
    begin
      unique case (state)
        ULK_HALF: next_state = key2_hit ? ULK_OPEN : (key1_hit ? ULK_HALF : ULK_IDLE);
        ULK_IDLE,
        ULK_OPEN: next_state = key1_hit ? ULK_HALF : ULK_IDLE;
        default:  next_state = ULK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ULK_IDLE;
    else
      state <= next_state;
  end

  assign open_o = (state == ULK_OPEN);

  a_open_after_keys: // see R10
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(open_o) |-> $past(state) == ULK_HALF && $past(key2_hit))
  else $error("unlock opened without key pair");

endmodule : pwmo_unlock

//--- src/pwmo_pin_path.sv
`timescale 1ns/100ps
module pwmo_pin_path (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic gen_active_i,
  input  wire logic port_level_i,
  input  wire logic owner_i,
  input  wire logic active_low_i,
  input  wire logic ovr_en_i,
  input  wire logic ovr_state_i,
  input  wire logic fault_force_i,
  input  wire logic fault_state_i,
  input  wire logic cl_force_i,
  input  wire logic cl_state_i,
  output logic      pin_o
);

  // Fault beats current limit beats override
  wire active_level = fault_force_i ? fault_state_i :  // see R7 see R14
                      cl_force_i    ? cl_state_i    :  // see R8
                      ovr_en_i      ? ovr_state_i   :  // see R5
                      gen_active_i;
  wire pin_level    = active_level ^ active_low_i;     // see R3
  wire next_pin     = owner_i ? pin_level : port_level_i; // see R1

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_o <= 1'b0;
    else
      pin_o <= next_pin;
  end

  a_fault_forces_pin: // see R7
  assert property (@(posedge clk_i) disable iff (rst_i)
    fault_force_i && owner_i |=> pin_o == ($past(fault_state_i) ^ $past(active_low_i)))
  else $error("fault state not driven on pin");

  a_limit_forces_pin: // see R8
  assert property (@(posedge clk_i) disable iff (rst_i)
    cl_force_i && !fault_force_i && owner_i |=> pin_o == ($past(cl_state_i) ^ $past(active_low_i)))
  else $error("current limit state not driven on pin");

  a_port_owns_pin: // see R1
  assert property (@(posedge clk_i) disable iff (rst_i)
    !owner_i |=> pin_o == $past(port_level_i))
  else $error("port level not passed when port owns pin");

  a_polarity_inverts: // see R3
  assert property (@(posedge clk_i) disable iff (rst_i)
    owner_i && !fault_force_i && !cl_force_i && !ovr_en_i
      |=> pin_o == ($past(gen_active_i) ^ $past(active_low_i)))
  else $error("generator level not shaped by polarity");

endmodule : pwmo_pin_path

//--- src/pwmo_out_ctrl.sv
// Functional notes
// R1: Per-pin ownership bit: one gives pin to generator, zero to port logic.
// R2: Reset sets both ownership bits; every other control field resets to zero.
// R3: Per-pin polarity bit: set means active-low, clear means active-high.
// R4: Two-bit pin-pair mode; code 11 is reserved, never a valid mode.
// R5: Per-pin override enable replaces generator with override data on that pin.
// R6: Override drives high pin from upper data bit, low pin from lower.
// R7: Enabled active fault forces high and low pins to fault-state bits.
// R8: Enabled active current limit forces pins to current-limit state bits.
// R9: Software should not change pin-pair mode while module is enabled.
// R10: With lock fuse set, control writes need a just-completed unlock sequence.
// R11: Swap bit exchanges high and low generator signals between the two pins.
// R12: Align bit makes override changes wait for the time-base tick.
// R13: Reserved mode drives both pins to inactive level, polarity honoured.
// R14: Precedence of forcing: fault, then current limit, then software override.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module pwmo_out_ctrl (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [pwmo_pkg::WB_ADR_W-1:0]   wb_adr_i,
  input  wire logic [pwmo_pkg::WB_DAT_W-1:0]   wb_dat_i,
  input  wire logic [pwmo_pkg::WB_SEL_W-1:0]   wb_sel_i,
  output logic      [pwmo_pkg::WB_DAT_W-1:0]   wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic [pwmo_pkg::FUSE_W-1:0]     device_option_fuses_i,
  input  wire logic                            pwm_module_enable_i,
  input  wire logic                            gen_high_i,
  input  wire logic                            gen_low_i,
  input  wire logic                            port_high_i,
  input  wire logic                            port_low_i,
  input  wire logic                            fault_mode_en_i,
  input  wire logic                            fault_active_i,
  input  wire logic                            cl_mode_en_i,
  input  wire logic                            cl_active_i,
  input  wire logic                            timebase_tick_i,
  output logic                                 high_side_output_o,
  output logic                                 low_side_output_o
);
  import pwmo_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic              phase;
  logic              eff_high_ovr_en;
  logic              eff_low_ovr_en;
  logic [1:0]        eff_ovr_state;
  logic              mode_changed_live;

  // Bus decode
  wire        bus_req    = wb_cyc_i && wb_stb_i;
  wire        bus_write  = bus_req && wb_we_i && wb_ack_o;
  wire        hit_ctrl   = (wb_adr_i == CTRL_OFS);
  wire        hit_unlock = (wb_adr_i == UNLOCK_OFS);
  wire        hit_status = (wb_adr_i == STATUS_OFS);

  // Lock and unlock
  wire        lock_fuse    = device_option_fuses_i[LOCK_FUSE_BIT];
  wire        unlock_open;
  wire        ctrl_wr_try  = bus_write && hit_ctrl;
  wire        ctrl_wr_ok   = ctrl_wr_try && (!lock_fuse || unlock_open); // see R10
  wire        key_we       = bus_write && hit_unlock && (&wb_sel_i[1:0]);

  // Control fields
  wire        high_pin_owner       = ctrl[HIGH_OWNER_BIT];
  wire        low_pin_owner        = ctrl[LOW_OWNER_BIT];
  wire        high_pin_active_low  = ctrl[HIGH_POL_BIT];
  wire        low_pin_active_low   = ctrl[LOW_POL_BIT];
  wire [1:0]  pin_pair_mode        = ctrl[MODE_LSB+1:MODE_LSB];
  wire        high_override_enable = ctrl[HIGH_OVR_BIT];
  wire        low_override_enable  = ctrl[LOW_OVR_BIT];
  wire [1:0]  override_state       = ctrl[OVR_LSB+1:OVR_LSB];
  wire [1:0]  fault_state          = ctrl[FLT_LSB+1:FLT_LSB];
  wire [1:0]  current_limit_state  = ctrl[CL_LSB+1:CL_LSB];
  wire        swap_pins            = ctrl[SWAP_BIT];
  wire        override_timebase_align = ctrl[ALIGN_BIT];

  // Mode decode
  wire        mode_reserved = (pin_pair_mode == MODE_RESERVED); // see R4
  wire        mode_high;
  wire        mode_low;
  assign mode_high = (pin_pair_mode == MODE_COMPL)     ? gen_high_i :
                     (pin_pair_mode == MODE_REDUNDANT) ? gen_high_i :
                     (pin_pair_mode == MODE_PUSH_PULL) ? (gen_high_i && !phase) :
                     1'b0;  // see R13
  assign mode_low  = (pin_pair_mode == MODE_COMPL)     ? gen_low_i :
                     (pin_pair_mode == MODE_REDUNDANT) ? gen_high_i :
                     (pin_pair_mode == MODE_PUSH_PULL) ? (gen_high_i && phase) :
                     1'b0;  // see R13

  // Swap routing
  wire        route_high = swap_pins ? mode_low  : mode_high; // see R11
  wire        route_low  = swap_pins ? mode_high : mode_low;  // see R11

  // Forcing conditions
  wire        fault_force = fault_mode_en_i && fault_active_i; // see R7
  wire        cl_force    = cl_mode_en_i && cl_active_i;       // see R8

  // Override load point
  wire        ovr_load = !override_timebase_align || timebase_tick_i; // see R12

  // Byte-lane merge of a control write
  wire [CTRL_W-1:0] next_ctrl = {wb_sel_i[1] ? wb_dat_i[15:8] : ctrl[15:8],
                                 wb_sel_i[0] ? wb_dat_i[7:0]  : ctrl[7:0]};

  // Read mux
  wire [7:0]  status_bits = {phase, mode_reserved, low_side_output_o, high_side_output_o,
                             cl_force, fault_force, unlock_open, lock_fuse};
  wire [WB_DAT_W-1:0] rd_data =
    hit_ctrl   ? {16'h0000, ctrl} :
    hit_status ? {23'h000000, mode_changed_live, status_bits} :
    32'h00000000;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= (bus_req && !wb_we_i && !wb_ack_o) ? rd_data : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= CTRL_RESET;  // see R2
    else if (ctrl_wr_ok)
      ctrl <= next_ctrl;   // see R10
  end

  // Mode written while module runs is taken as written and flagged
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_changed_live <= 1'b0;
    else if (ctrl_wr_ok && pwm_module_enable_i &&
             (next_ctrl[MODE_LSB+1:MODE_LSB] != pin_pair_mode))
      mode_changed_live <= 1'b1;  // see R9
    else if (bus_write && hit_status && wb_sel_i[1] && wb_dat_i[8])
      mode_changed_live <= 1'b0;
  end

  // Push-pull phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase <= 1'b0;
    else if (timebase_tick_i)
      phase <= !phase;
  end

  // Override data as seen by the pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eff_high_ovr_en <= 1'b0;
      eff_low_ovr_en  <= 1'b0;
      eff_ovr_state   <= 2'b00;
    end
    else if (ovr_load)  // see R12
    begin
      eff_high_ovr_en <= high_override_enable;
      eff_low_ovr_en  <= low_override_enable;
      eff_ovr_state   <= override_state;
    end
  end

  pwmo_unlock u_unlock (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .key_we_i  (key_we),
    .key_i     (wb_dat_i[15:0]),
    .consume_i (ctrl_wr_try),
    .open_o    (unlock_open)
  );

  pwmo_pin_path u_high (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .gen_active_i  (route_high),
    .port_level_i  (port_high_i),
    .owner_i       (high_pin_owner),
    .active_low_i  (high_pin_active_low),
    .ovr_en_i      (eff_high_ovr_en),
    .ovr_state_i   (eff_ovr_state[1]),  // see R6
    .fault_force_i (fault_force),
    .fault_state_i (fault_state[1]),
    .cl_force_i    (cl_force),
    .cl_state_i    (current_limit_state[1]),
    .pin_o         (high_side_output_o)
  );

  pwmo_pin_path u_low (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .gen_active_i  (route_low),
    .port_level_i  (port_low_i),
    .owner_i       (low_pin_owner),
    .active_low_i  (low_pin_active_low),
    .ovr_en_i      (eff_low_ovr_en),
    .ovr_state_i   (eff_ovr_state[0]),  // see R6
    .fault_force_i (fault_force),
    .fault_state_i (fault_state[0]),
    .cl_force_i    (cl_force),
    .cl_state_i    (current_limit_state[0]),
    .pin_o         (low_side_output_o)
  );

  a_ack_single_pulse:
  assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
  else $error("ack held longer than one cycle");

  a_reset_owns_pins: // see R2
  assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> ctrl == CTRL_RESET)
  else $error("control not at reset value after reset");

  a_locked_write_dropped: // see R10
  assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_try && lock_fuse && !unlock_open |=> $stable(ctrl))
  else $error("locked control write took effect");

  a_unlock_single_use: // see R10
  assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_try |=> !unlock_open)
  else $error("unlock survived a control write");

  a_swap_routes_low: // see R11
  assert property (@(posedge clk_i) disable iff (rst_i)
    swap_pins && high_pin_owner && !high_pin_active_low && !eff_high_ovr_en &&
    !fault_force && !cl_force && pin_pair_mode == MODE_COMPL
      |=> high_side_output_o == $past(gen_low_i))
  else $error("swap did not route low signal to high pin");

  a_reserved_mode_idle: // see R13
  assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reserved && low_pin_owner && !eff_low_ovr_en && !fault_force && !cl_force
      |=> low_side_output_o == $past(low_pin_active_low))
  else $error("reserved mode did not idle the pin");

  a_align_holds_ovr: // see R12
  assert property (@(posedge clk_i) disable iff (rst_i)
    override_timebase_align && !timebase_tick_i |=> $stable(eff_ovr_state) && $stable(eff_high_ovr_en))
  else $error("override changed between time-base ticks");

  a_override_drives: // see R5
  assert property (@(posedge clk_i) disable iff (rst_i)
    eff_high_ovr_en && high_pin_owner && !fault_force && !cl_force
      |=> high_side_output_o == ($past(eff_ovr_state[1]) ^ $past(high_pin_active_low)))
  else $error("override data not on high pin");

  a_fault_over_limit: // see R14
  assert property (@(posedge clk_i) disable iff (rst_i)
    fault_force && cl_force && low_pin_owner
      |=> low_side_output_o == ($past(fault_state[0]) ^ $past(low_pin_active_low)))
  else $error("current limit won over fault");

  a_owners_reset: // see R2
  assert property (@(posedge clk_i)
    rst_i |=> ctrl == CTRL_RESET && !wb_ack_o)
  else $error("reset did not restore control");

  a_write_lands: // see R10
  assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_ok && (&wb_sel_i[1:0]) |=> ctrl == $past(wb_dat_i[15:0]))
  else $error("accepted control write did not land");

  a_read_returns_ctrl:
  assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_we_i && !wb_ack_o && hit_ctrl |=> wb_ack_o && wb_dat_o == {16'h0000, $past(ctrl)})
  else $error("control read data wrong");

  a_unmapped_reads_zero:
  assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_ack_o && !hit_ctrl && !hit_status |=> wb_dat_o == 32'h00000000)
  else $error("unmapped address returned data");

  a_redundant_copies: // see R4
  assert property (@(posedge clk_i) disable iff (rst_i)
    pin_pair_mode == MODE_REDUNDANT && !swap_pins && low_pin_owner && !low_pin_active_low &&
    !eff_low_ovr_en && !fault_force && !cl_force
      |=> low_side_output_o == $past(gen_high_i))
  else $error("redundant mode did not copy high signal");

  a_ovr_loads_free: // see R12
  assert property (@(posedge clk_i) disable iff (rst_i)
    !override_timebase_align |=> eff_ovr_state == $past(override_state))
  else $error("override not taken at next clock");

  a_flag_clears: // see R9
  assert property (@(posedge clk_i) disable iff (rst_i)
    bus_write && hit_status && wb_sel_i[1] && wb_dat_i[8] |=> !mode_changed_live)
  else $error("mode change flag not cleared");

endmodule : pwmo_out_ctrl

//--- verification/pwmo_power_stage.sv
`timescale 1ns/100ps
module pwmo_power_stage (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic high_gate_i,
  input  wire logic low_gate_i,
  output logic      overlap_o
);
  // Sticky record of both switches conducting at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overlap_o <= 1'b0;
    else if (high_gate_i && low_gate_i)
      overlap_o <= 1'b1;
  end
endmodule : pwmo_power_stage

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
  import pwmo_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] rdat;
  logic [7:0]  fuse  = 8'h00;
  logic        en    = 1'b0;
  logic        gh    = 1'b0;
  logic        gl    = 1'b0;
  logic        ph    = 1'b0;
  logic        pl    = 1'b0;
  logic        fm    = 1'b0;
  logic        fa    = 1'b0;
  logic        cm    = 1'b0;
  logic        ca    = 1'b0;
  logic        tick  = 1'b0;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire         hi_o;
  wire         lo_o;
  wire         overlap;
  int          fail_count = 0;
  int          checked    = 0;
  int          cycles     = 0;

  pwmo_out_ctrl DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .device_option_fuses_i(fuse), .pwm_module_enable_i(en), .gen_high_i(gh), .gen_low_i(gl),
    .port_high_i(ph), .port_low_i(pl), .fault_mode_en_i(fm), .fault_active_i(fa),
    .cl_mode_en_i(cm), .cl_active_i(ca), .timebase_tick_i(tick),
    .high_side_output_o(hi_o), .low_side_output_o(lo_o)
  );

  pwmo_power_stage stage (
    .clk_i(clk_i), .rst_i(rst_i), .high_gate_i(hi_o), .low_gate_i(lo_o), .overlap_o(overlap)
  );

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20)
      fail_count++;
    rdat = dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
  endtask : wb

  task automatic pins(input logic h, input logic l);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("high pin", {31'h0, hi_o}, {31'h0, h});
    check("low pin", {31'h0, lo_o}, {31'h0, l});
    @(posedge clk_i);
  endtask : pins

  task automatic t_reset;
    @(posedge clk_i);
    gh <= 1'b1;
    wb(1'b0, CTRL_OFS, 32'h0, 4'h3);
    check("ctrl reset", rdat, 32'h0000c000);
    pins(1'b1, 1'b0);
    check("no overlap", {31'h0, overlap}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_own_pol;
    @(posedge clk_i);
    gh <= 1'b0;
    gl <= 1'b1;
    ph <= 1'b1;
    pl <= 1'b1;
    wb(1'b1, CTRL_OFS, 32'h0000, 4'h3);
    pins(1'b1, 1'b1);
    check("overlap seen", {31'h0, overlap}, 32'h1);
    wb(1'b1, CTRL_OFS, 32'hf000, 4'h3);
    pins(1'b1, 1'b0);
    wb(1'b1, CTRL_OFS, 32'hc000, 4'h3);
    pins(1'b0, 1'b1);
    $display("test ownership and polarity done");
  endtask : t_own_pol

  task automatic t_mode;
    @(posedge clk_i);
    gh <= 1'b1;
    gl <= 1'b0;
    wb(1'b1, CTRL_OFS, 32'hc400, 4'h3);
    pins(1'b1, 1'b1);
    wb(1'b1, CTRL_OFS, 32'hc800, 4'h3);
    pins(1'b1, 1'b0);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    pins(1'b0, 1'b1);
    wb(1'b1, CTRL_OFS, 32'hcc00, 4'h3);
    pins(1'b0, 1'b0);
    wb(1'b1, CTRL_OFS, 32'hfc00, 4'h3);
    pins(1'b1, 1'b1);
    wb(1'b1, CTRL_OFS, 32'hc002, 4'h3);
    pins(1'b0, 1'b1);
    $display("test modes and swap done");
  endtask : t_mode

  task automatic t_force;
    @(posedge clk_i);
    gh <= 1'b0;
    gl <= 1'b0;
    fm <= 1'b1;
    fa <= 1'b1;
    cm <= 1'b1;
    ca <= 1'b1;
    wb(1'b1, CTRL_OFS, 32'hc3d8, 4'h3);
    pins(1'b0, 1'b1);
    fa <= 1'b0;
    pins(1'b1, 1'b0);
    ca <= 1'b0;
    pins(1'b1, 1'b1);
    fm <= 1'b0;
    fa <= 1'b1;
    pins(1'b1, 1'b1);
    fa <= 1'b0;
    cm <= 1'b0;
    $display("test forcing done");
  endtask : t_force

  task automatic t_align;
    @(posedge clk_i);
    gh <= 1'b1;
    gl <= 1'b1;
    wb(1'b1, CTRL_OFS, 32'hc300, 4'h3);
    pins(1'b0, 1'b0);
    wb(1'b1, CTRL_OFS, 32'hc3c1, 4'h3);
    pins(1'b0, 1'b0);
    @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    pins(1'b1, 1'b1);
    $display("test override alignment done");
  endtask : t_align

  task automatic t_lock;
    wb(1'b1, CTRL_OFS, 32'hc000, 4'h3);
    fuse <= 8'h01;
    wb(1'b1, CTRL_OFS, 32'h0000, 4'h3);
    wb(1'b0, CTRL_OFS, 32'h0, 4'h3);
    check("locked ctrl", rdat, 32'h0000c000);
    wb(1'b1, UNLOCK_OFS, {16'h0, UNLOCK_KEY1}, 4'h3);
    wb(1'b1, UNLOCK_OFS, {16'h0, UNLOCK_KEY2}, 4'h3);
    wb(1'b1, CTRL_OFS, 32'hc400, 4'h3);
    wb(1'b0, CTRL_OFS, 32'h0, 4'h3);
    check("unlocked ctrl", rdat, 32'h0000c400);
    wb(1'b1, CTRL_OFS, 32'hc000, 4'h3);
    wb(1'b0, CTRL_OFS, 32'h0, 4'h3);
    check("relocked ctrl", rdat, 32'h0000c400);
    wb(1'b0, UNLOCK_OFS, 32'h0, 4'h3);
    check("unlock readback", rdat, 32'h0);
    wb(1'b1, 8'h0c, 32'hffffffff, 4'hf);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    check("unmapped read", rdat, 32'h0);
    fuse <= 8'h00;
    $display("test lock done");
  endtask : t_lock

  task automatic t_run_mode;
    @(posedge clk_i);
    en <= 1'b1;
    wb(1'b1, CTRL_OFS, 32'hc800, 4'h3);
    wb(1'b0, STATUS_OFS, 32'h0, 4'h3);
    check("mode change flag", {31'h0, rdat[8]}, 32'h1);
    wb(1'b1, STATUS_OFS, 32'h100, 4'h2);
    wb(1'b0, STATUS_OFS, 32'h0, 4'h3);
    check("flag cleared", {31'h0, rdat[8]}, 32'h0);
    en <= 1'b0;
    $display("test mode change while running done");
  endtask : t_run_mode

  task automatic t_mid_reset;
    @(posedge clk_i);
    ph <= 1'b0;
    pl <= 1'b0;
    wb(1'b1, CTRL_OFS, 32'h0000, 4'h3);
    pins(1'b0, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0, 4'h3);
    check("ctrl after reset", rdat, 32'h0000c000);
    pins(1'b1, 1'b1);
    $display("test mid-run reset done");
  endtask : t_mid_reset

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_own_pol();
    t_mode();
    t_force();
    t_align();
    t_lock();
    t_run_mode();
    t_mid_reset();
    summarize();
  end
endmodule : tb
